// ==== hdl/tscsw_consts.vh ====
`ifndef TSCSW_CONSTS_VH
`define TSCSW_CONSTS_VH

// function codes on the channel command port
`define TSCSW_FC_IN_INTCTL    7'h02
`define TSCSW_FC_OUT_INTCTL   7'h03
`define TSCSW_FC_OUT_TASK     7'h07
`define TSCSW_FC_IN_STATUS1   7'h18

// primary status word bit positions
`define TSCSW_BIT_READY       0
`define TSCSW_BIT_ATTN        1
`define TSCSW_BIT_RETRY       2
`define TSCSW_BIT_FAULT       3
`define TSCSW_BIT_CORR        4
`define TSCSW_BIT_TMARK       5
`define TSCSW_BIT_START       6
`define TSCSW_BIT_END         7

// secondary status fields
`define TSCSW_SEC_RETRY_LO    4
`define TSCSW_SEC_RETRY_HI    7
`define TSCSW_SEC_FAULT_LO    12
`define TSCSW_SEC_FAULT_HI    14

// interrupt level field and reset values
`define TSCSW_LEVEL_W         6
`define TSCSW_LEVEL_RST       6'h00
`define TSCSW_WORD_RST        16'h0000

// drive pin vector positions
`define TSCSW_PIN_ONLINE      0
`define TSCSW_PIN_REWIND      1
`define TSCSW_PIN_LOADED      2
`define TSCSW_PIN_START       3
`define TSCSW_PIN_END         4
`define TSCSW_PIN_COUNT       5

`endif

// ==== hdl/tscsw_sync.v ====
module tscsw_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1_q;
      reg stage2_q;
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1_q <= 1'b0;
          stage2_q <= 1'b0;
        end else begin
          stage1_q <= asyncIn[i];
          stage2_q <= stage1_q;
        end
      end
      assign syncOut[i] = stage2_q;
    end
  endgenerate

endmodule

// ==== hdl/tscsw_status_flags.v ====
// How it works
// [RQ1] attention set on unsolicited drive event
// [RQ2] readiness change without command raises attention
// [RQ3] stop or initialize during rewind raises attention
// [RQ4] attention set attempts interrupt if level nonzero
// [RQ5] change during operation gives one combined interrupt
// [RQ6] initialize or status read clears attention
// [RQ7] retryable flag from secondary bits 4 to 7
// [RQ8] subsystem fault flag, cause in secondary 12-14
// [RQ9] corrected flag on PE/GCR track correction
// [RQ10] corrected flag on successful read retry
// [RQ11] media flags cleared by initialize or task write
// [RQ12] tape mark flag on mark detection orders
// [RQ13] start marker bit follows sensor directly
// [RQ14] backward order at start: no motion, normal end
// [RQ15] end flag holds until backward motion recrosses
// [RQ16] forward motion ignores end flag
// [RQ17] status read returns word in response cycle
// [RQ18] interrupt level resets to zero
// [RQ19] pins synchronised, changes found against previous
`include "tscsw_consts.vh"

module tscsw_status_flags #(
  parameter LEVEL_W = `TSCSW_LEVEL_W
) (
  input  wire               core_clk,
  input  wire               arst_n,
  // channel command port
  input  wire               cmdValid,
  input  wire [6:0]         cmdFunc,
  input  wire [15:0]        cmdData,
  input  wire               initCmd,
  input  wire               stopIoCmd,
  output reg                rspValid_q,
  output reg  [15:0]        rspData_q,
  output reg                intReq_q,
  output reg  [LEVEL_W-1:0] intLevel_q,
  // drive condition pins
  input  wire               driveOnline,
  input  wire               driveRewinding,
  input  wire               driveLoaded,
  input  wire               driveAtStart,
  input  wire               driveAtEnd,
  // formatter unit signals
  input  wire [15:0]        secStatus,
  input  wire               swMotionCmd,
  input  wire               opActive,
  input  wire               opDone,
  input  wire               peSingleCorr,
  input  wire               gcrCorr,
  input  wire               retryOk,
  input  wire               markInMarkOrder,
  input  wire               markAsBlock,
  input  wire               faultUnbound,
  // motion order port
  input  wire               orderValid,
  input  wire               orderBackward,
  output reg                motionGo_q,
  output reg                motionBackward_q,
  output reg                orderNormalEnd_q
);

  wire [`TSCSW_PIN_COUNT-1:0] pinRaw;
  wire [`TSCSW_PIN_COUNT-1:0] pinSync;
  reg  [`TSCSW_PIN_COUNT-1:0] pinPrev_q;

  reg  attn_q;
  reg  attnPend_q;
  reg  rewindAbort_q;
  reg  retryErr_q;
  reg  corrErr_q;
  reg  tapeMark_q;
  reg  endFlag_q;
  reg  fault_q;
  reg  backDir_q;

  reg  attn_d;
  reg  attnPend_d;
  reg  retryErr_d;
  reg  corrErr_d;
  reg  tapeMark_d;
  reg  endFlag_d;

  wire readStatus;
  wire taskWrite;
  wire levelWrite;
  wire readLevel;
  wire readyChange;
  wire attnEvent;
  wire attnRise;
  wire [15:0] statusWord;
  wire [`TSCSW_PIN_COUNT-1:0] pinEdge;

  function cmdIs;
    input [6:0] code;
    begin
      cmdIs = cmdValid && (cmdFunc == code);
    end
  endfunction

  assign pinRaw[`TSCSW_PIN_ONLINE] = driveOnline;
  assign pinRaw[`TSCSW_PIN_REWIND] = driveRewinding;
  assign pinRaw[`TSCSW_PIN_LOADED] = driveLoaded;
  assign pinRaw[`TSCSW_PIN_START]  = driveAtStart;
  assign pinRaw[`TSCSW_PIN_END]    = driveAtEnd;

  // drive pins come from another timing domain
  tscsw_sync #(
    .WIDTH (`TSCSW_PIN_COUNT)
  ) u_pin_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .asyncIn  (pinRaw),
    .syncOut  (pinSync)
  ); // RQ19

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinPrev_q <= {`TSCSW_PIN_COUNT{1'b0}};
    end else begin
      pinPrev_q <= pinSync; // RQ19
    end
  end

  assign readStatus = cmdIs(`TSCSW_FC_IN_STATUS1);
  assign taskWrite  = cmdIs(`TSCSW_FC_OUT_TASK);
  assign levelWrite = cmdIs(`TSCSW_FC_OUT_INTCTL);
  assign readLevel  = cmdIs(`TSCSW_FC_IN_INTCTL);

  // per-pin change against the previous synced level
  genvar k;
  generate
    for (k = 0; k < `TSCSW_PIN_COUNT; k = k + 1) begin : g_edge
      assign pinEdge[k] = pinSync[k] ^ pinPrev_q[k]; // RQ19
    end
  endgenerate

  // online, rewinding or loaded moved on its own
  assign readyChange = (pinEdge[`TSCSW_PIN_ONLINE] ||
                        pinEdge[`TSCSW_PIN_REWIND] ||
                        pinEdge[`TSCSW_PIN_LOADED]) &&
                       !swMotionCmd; // RQ2

  // stop/initialize while rewinding is remembered one cycle
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rewindAbort_q <= 1'b0;
    end else begin
      rewindAbort_q <= (initCmd || stopIoCmd) &&
                       pinSync[`TSCSW_PIN_REWIND]; // RQ3
    end
  end

  assign attnEvent = readyChange || rewindAbort_q; // RQ1

  // pending event held while an operation runs
  always @* begin
    attnPend_d = attnPend_q;
    attn_d     = attn_q;
    if (initCmd || readStatus) begin
      attn_d = 1'b0; // RQ6
    end
    if (initCmd) begin
      attnPend_d = 1'b0;
    end
    if (attnEvent) begin
      attnPend_d = 1'b1;
    end
    // one interrupt serves both completion and change
    if ((attnPend_q || attnEvent) && (!opActive || opDone)) begin
      attn_d     = 1'b1; // RQ5
      attnPend_d = 1'b0;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      attn_q     <= 1'b0;
      attnPend_q <= 1'b0;
    end else begin
      attn_q     <= attn_d; // RQ1
      attnPend_q <= attnPend_d;
    end
  end

  assign attnRise = attn_d && !attn_q;

  // interrupt attempt per attention setting
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      intReq_q <= 1'b0;
    end else begin
      intReq_q <= attnRise && (intLevel_q != {LEVEL_W{1'b0}}); // RQ4
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      intLevel_q <= `TSCSW_LEVEL_RST; // RQ18
    end else if (initCmd) begin
      intLevel_q <= `TSCSW_LEVEL_RST; // RQ18
    end else if (levelWrite) begin
      intLevel_q <= cmdData[LEVEL_W-1:0];
    end
  end

  // sticky media flags: a set in the clearing cycle wins
  always @* begin
    retryErr_d = retryErr_q;
    corrErr_d  = corrErr_q;
    tapeMark_d = tapeMark_q;
    if (initCmd || taskWrite) begin
      retryErr_d = 1'b0; // RQ11
      corrErr_d  = 1'b0; // RQ11
      tapeMark_d = 1'b0; // RQ11
    end
    if (|secStatus[`TSCSW_SEC_RETRY_HI:`TSCSW_SEC_RETRY_LO]) begin
      retryErr_d = 1'b1; // RQ7
    end
    if (peSingleCorr || gcrCorr) begin
      corrErr_d = 1'b1; // RQ9
    end
    if (retryOk) begin
      corrErr_d = 1'b1; // RQ10
    end
    if (markInMarkOrder || markAsBlock) begin
      tapeMark_d = 1'b1; // RQ12
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      retryErr_q <= 1'b0;
      corrErr_q  <= 1'b0;
      tapeMark_q <= 1'b0;
    end else begin
      retryErr_q <= retryErr_d;
      corrErr_q  <= corrErr_d;
      tapeMark_q <= tapeMark_d;
    end
  end

  // fault reported with a cause code, no software reset
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= faultUnbound &&
        (|secStatus[`TSCSW_SEC_FAULT_HI:`TSCSW_SEC_FAULT_LO]); // RQ8
    end
  end

  // end marker flag drops only when backing over the sensor
  always @* begin
    endFlag_d = endFlag_q;
    if (pinSync[`TSCSW_PIN_END]) begin
      endFlag_d = 1'b1; // RQ15
    end else if (pinPrev_q[`TSCSW_PIN_END] && backDir_q) begin
      endFlag_d = 1'b0; // RQ15
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      endFlag_q <= 1'b0;
    end else begin
      endFlag_q <= endFlag_d;
    end
  end

  // motion order gate; end flag never blocks forward moves
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      motionGo_q       <= 1'b0;
      motionBackward_q <= 1'b0;
      orderNormalEnd_q <= 1'b0;
      backDir_q        <= 1'b0;
    end else begin
      motionGo_q       <= 1'b0;
      orderNormalEnd_q <= 1'b0;
      if (orderValid) begin
        if (orderBackward && pinSync[`TSCSW_PIN_START]) begin
          orderNormalEnd_q <= 1'b1; // RQ14
        end else begin
          motionGo_q       <= 1'b1; // RQ16
          motionBackward_q <= orderBackward;
          backDir_q        <= orderBackward;
        end
      end
    end
  end

  assign statusWord = {8'h00,
                       endFlag_q,
                       pinSync[`TSCSW_PIN_START], // RQ13
                       tapeMark_q,
                       corrErr_q,
                       fault_q,
                       retryErr_q,
                       attn_q,
                       1'b0};

  // response cycle answers input commands
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rspValid_q <= 1'b0;
      rspData_q  <= `TSCSW_WORD_RST;
    end else begin
      rspValid_q <= readStatus || readLevel;
      if (readStatus) begin
        rspData_q <= statusWord; // RQ17
      end else if (readLevel) begin
        rspData_q <= {{(16-LEVEL_W){1'b0}}, intLevel_q};
      end
    end
  end

endmodule

// ==== bench/tscsw_status_flags_properties.sv ====
module tscsw_status_flags_properties #(
  parameter LEVEL_W = 6
) (
  input wire               core_clk,
  input wire               arst_n,
  input wire               cmdValid,
  input wire [6:0]         cmdFunc,
  input wire               initCmd,
  input wire               rspValid_q,
  input wire [15:0]        rspData_q,
  input wire               intReq_q,
  input wire [LEVEL_W-1:0] intLevel_q,
  input wire               driveAtStart,
  input wire [15:0]        secStatus,
  input wire               faultUnbound,
  input wire               orderValid,
  input wire               orderBackward,
  input wire               motionGo_q,
  input wire               orderNormalEnd_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd;
    cmdValid && cmdFunc == 7'h18;
  endsequence
  sequence s_back_at_start;
    driveAtStart [*4] ##0 (orderValid && orderBackward);
  endsequence
  a_rsp_answer: assert property (s_rd |=> rspValid_q)
    else $error("status read not answered");
  a_rsp_source: assert property (rspValid_q |-> $past(cmdValid) &&
    ($past(cmdFunc) == 7'h18 || $past(cmdFunc) == 7'h02))
    else $error("answer without read");
  a_word_zeros: assert property (s_rd |=> !rspData_q[0] &&
    rspData_q[15:8] == 8'h00) else $error("unused status bits set");
  a_level_init: assert property (initCmd |=> intLevel_q == '0)
    else $error("level kept over initialize");
  a_int_level: assert property (intReq_q |-> $past(intLevel_q) != '0)
    else $error("interrupt at level zero");
  a_int_pulse: assert property (intReq_q |=> !intReq_q)
    else $error("interrupt repeated");
  a_start_back: assert property (s_back_at_start |=>
    orderNormalEnd_q && !motionGo_q) else $error("motion at start");
  a_forward_go: assert property (orderValid && !orderBackward |=>
    motionGo_q && !orderNormalEnd_q) else $error("forward not started");
  a_retry_bit: assert property ((|secStatus[7:4]) [*2] ##0 s_rd
    |=> rspData_q[2]) else $error("retryable flag missing");
  a_fault_bit: assert property ((faultUnbound &&
    |secStatus[14:12]) [*2] ##0 s_rd |=> rspData_q[3])
    else $error("fault flag missing");
endmodule

bind tscsw_status_flags tscsw_status_flags_properties #(.LEVEL_W(LEVEL_W))
  u_props (.*);

// ==== bench/tscsw_host.sv ====
module tscsw_host (
  input  wire         core_clk,
  input  wire         rspValid_q,
  input  wire  [15:0] rspData_q,
  output logic        cmdValid,
  output logic [6:0]  cmdFunc,
  output logic [15:0] cmdData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmdValid = 1'b0;
    cmdFunc = 7'h00;
    cmdData = 16'h0000;
  end
  // one-cycle strobe; data scrambled once released
  task automatic put(input logic [6:0] f, input logic [15:0] d);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdFunc <= f;
    cmdData <= d;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdData <= ~d;
  endtask
  task automatic rd(output logic [15:0] w);
    put(7'h18, 16'h0000);
    w = 16'hxxxx;
    @(negedge core_clk);
    if (rspValid_q === 1'b1) w = rspData_q;
  endtask
endmodule

// ==== bench/tb_tscsw_status_flags.sv ====
module tb_tscsw_status_flags;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        initCmd = 1'b0;
  logic [4:0]  pins = 5'h00;
  logic [15:0] secStatus = 16'h0000;
  logic [4:0]  ev = 5'h00;
  logic [2:0]  ctl = 3'h0;
  logic [1:0]  ord = 2'h0;
  logic        stopIo = 1'b0;
  logic        swMotion = 1'b0;
  wire         motionBackward_q;
  logic [15:0] w;
  logic        hit;
  int          fail_count = 0;
  int          tests_run = 0;
  wire         cmdValid, rspValid_q, intReq_q, motionGo_q, orderNormalEnd_q;
  wire  [6:0]  cmdFunc;
  wire  [15:0] cmdData, rspData_q;
  wire  [5:0]  intLevel_q;
  always #10 core_clk = ~core_clk;
  tscsw_host u_host (.core_clk(core_clk), .rspValid_q(rspValid_q),
    .rspData_q(rspData_q), .cmdValid(cmdValid), .cmdFunc(cmdFunc),
    .cmdData(cmdData));
  tscsw_status_flags u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .cmdValid(cmdValid), .cmdFunc(cmdFunc), .cmdData(cmdData),
    .initCmd(initCmd), .stopIoCmd(stopIo), .rspValid_q(rspValid_q),
    .rspData_q(rspData_q), .intReq_q(intReq_q), .intLevel_q(intLevel_q),
    .driveOnline(pins[0]), .driveRewinding(pins[1]),
    .driveLoaded(pins[2]), .driveAtStart(pins[3]), .driveAtEnd(pins[4]),
    .secStatus(secStatus), .swMotionCmd(swMotion), .opActive(ctl[0]),
    .opDone(ctl[1]), .peSingleCorr(ev[0]), .gcrCorr(ev[1]),
    .retryOk(ev[2]), .markInMarkOrder(ev[3]), .markAsBlock(ev[4]),
    .faultUnbound(ctl[2]), .orderValid(ord[0]), .orderBackward(ord[1]),
    .motionGo_q(motionGo_q), .motionBackward_q(motionBackward_q),
    .orderNormalEnd_q(orderNormalEnd_q));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic waitInt(output logic h);
    h = 1'b0;
    repeat (8) begin
      @(negedge core_clk);
      if (intReq_q === 1'b1) h = 1'b1;
    end
  endtask
  task automatic order(input logic [1:0] o);
    ord <= o;
    @(posedge core_clk);
    ord <= 2'h0;
    @(negedge core_clk);
  endtask
  task automatic pulseInit;
    initCmd <= 1'b1;
    @(posedge core_clk);
    initCmd <= 1'b0;
  endtask
  task automatic test_done;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(3);
    arst_n <= 1'b1;
    tick(1);
    chk({10'h000, intLevel_q}, 16'h0000);
    u_host.rd(w);
    chk(w, 16'h0000);
    u_host.put(7'h03, 16'h0005);
    tick(1);
    chk({10'h000, intLevel_q}, 16'h0005);
    pins[0] <= 1'b1;
    waitInt(hit);
    chk({15'h0, hit}, 16'h0001);
    u_host.rd(w);
    chk(w & 16'h0002, 16'h0002);
    u_host.rd(w);
    chk(w & 16'h0002, 16'h0000);
    ctl <= 3'h1;
    pins[2] <= 1'b1;
    waitInt(hit);
    chk({15'h0, hit}, 16'h0000);
    ctl <= 3'h2;
    @(posedge core_clk);
    ctl <= 3'h0;
    waitInt(hit);
    chk({15'h0, hit}, 16'h0001);
    secStatus <= 16'h0020;
    tick(2);
    u_host.rd(w);
    chk(w & 16'h0004, 16'h0004);
    secStatus <= 16'h0000;
    tick(2);
    u_host.rd(w);
    chk(w & 16'h0004, 16'h0004);
    u_host.put(7'h07, 16'h0000);
    u_host.rd(w);
    chk(w & 16'h0004, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      pulseInit();
      ev <= 5'h01 << i;
      @(posedge core_clk);
      ev <= 5'h00;
      u_host.rd(w);
      chk(w & 16'h0030, i < 3 ? 16'h0010 : 16'h0020);
    end
    pulseInit();
    u_host.rd(w);
    chk(w & 16'h0036, 16'h0000);
    chk({10'h000, intLevel_q}, 16'h0000);
    ctl <= 3'h4;
    secStatus <= 16'h1000;
    tick(2);
    u_host.rd(w);
    chk(w & 16'h0008, 16'h0008);
    ctl <= 3'h0;
    secStatus <= 16'h0000;
    tick(2);
    u_host.rd(w);
    chk(w & 16'h0008, 16'h0000);
    pins[3] <= 1'b1;
    tick(4);
    u_host.rd(w);
    chk(w & 16'h0040, 16'h0040);
    order(2'h3);
    chk({14'h0, motionGo_q, orderNormalEnd_q}, 16'h0001);
    pins <= 5'h15;
    tick(4);
    order(2'h1);
    chk({15'h0, motionBackward_q}, 16'h0000);
    chk({14'h0, motionGo_q, orderNormalEnd_q}, 16'h0002);
    pins <= 5'h05;
    tick(4);
    u_host.rd(w);
    chk(w & 16'h0080, 16'h0080);
    order(2'h3);
    chk({15'h0, motionBackward_q}, 16'h0001);
    pins <= 5'h15;
    tick(4);
    pins <= 5'h05;
    tick(4);
    u_host.rd(w);
    chk(w & 16'h0080, 16'h0000);
    pins <= 5'h07;
    waitInt(hit);
    chk({15'h0, hit}, 16'h0000);
    u_host.rd(w);
    chk(w & 16'h0002, 16'h0002);
    u_host.put(7'h03, 16'h0005);
    stopIo <= 1'b1;
    @(posedge core_clk);
    stopIo <= 1'b0;
    waitInt(hit);
    chk({15'h0, hit}, 16'h0001);
    u_host.rd(w);
    chk(w & 16'h0002, 16'h0002);
    swMotion <= 1'b1;
    pins <= 5'h05;
    waitInt(hit);
    chk({15'h0, hit}, 16'h0000);
    swMotion <= 1'b0;
    u_host.rd(w);
    chk(w & 16'h0002, 16'h0000);
    test_done();
  end
endmodule
